// *** logic/cal_path_pkg.sv ***
// shared constants for the result and calibration path
package cal_path_pkg;
    localparam int PAD_W       = 6;
    localparam logic [23:0] COEFF_RESET  = 24'h000000;
    localparam logic [23:0] RESULT_RESET = 24'h000000;
    // gain: 0x400000 is 1.0, 0x7FFFFF just under 2.0
    localparam int GAIN_FRAC   = 22;
    localparam logic [17:0] UNI_MAX   = 18'h3FFFF;
    localparam logic [17:0] UNI_MIN   = 18'h00000;
    localparam logic [17:0] OFFB_MID  = 18'h20000;
    localparam logic [17:0] TWOS_MAX  = 18'h1FFFF;
    localparam logic [17:0] TWOS_MIN  = 18'h20000;
    // register selects
    localparam logic [2:0] SEL_RESULT      = 3'h0;
    localparam logic [2:0] SEL_SYS_OFFSET  = 3'h1;
    localparam logic [2:0] SEL_SYS_GAIN    = 3'h2;
    localparam logic [2:0] SEL_SELF_OFFSET = 3'h3;
    localparam logic [2:0] SEL_SELF_GAIN   = 3'h4;
    localparam logic [4:0] LAST_BIT        = 5'h17;
    // data rate in milli-samples per second, per code
    localparam logic [19:0] RATE_60_SINGLE [8] = '{20'd1000, 20'd2500, 20'd5000, 20'd10000,
                                                  20'd15000, 20'd30000, 20'd60000, 20'd120000};
    localparam logic [19:0] RATE_60_CONT   [8] = '{20'd0, 20'd0, 20'd0, 20'd0,
                                                  20'd60000, 20'd120000, 20'd240000, 20'd480000};
    localparam logic [19:0] RATE_50_SINGLE [8] = '{20'd833, 20'd2080, 20'd4170, 20'd8330,
                                                  20'd12500, 20'd25000, 20'd50000, 20'd100000};
    localparam logic [19:0] RATE_50_CONT   [8] = '{20'd0, 20'd0, 20'd0, 20'd0,
                                                  20'd50000, 20'd100000, 20'd200000, 20'd400000};
    typedef enum logic [1:0] {SH_IDLE, SH_LOAD, SH_SHIFT} shift_state_e;
endpackage : cal_path_pkg

// *** logic/cal_stage.sv ***
// one offset-subtract then gain-scale correction stage
`timescale 1ns/1ps
`default_nettype none
module cal_stage
(
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    input  wire logic                in_valid,
    input  wire logic signed [39:0]  in_value,
    input  wire logic [23:0]         offset_coeff,
    input  wire logic [23:0]         gain_coeff,
    input  wire logic                offset_disable,
    input  wire logic                gain_disable,
    output logic                     out_valid,
    output logic signed [39:0]       out_value
);
    typedef struct packed
    {
        logic               mid_valid;
        logic signed [39:0] mid_value;
        logic               valid;
        logic signed [39:0] value;
    } stage_s;

    stage_s st_r;
    stage_s st_nxt;
    logic signed [64:0] product;

    always_comb
    begin
        st_nxt = st_r;
        product = 65'sd0;
        if (clk_en)
        begin
            st_nxt.mid_valid = in_valid;
            st_nxt.mid_value = offset_disable ? in_value
                             : in_value - 40'(signed'(offset_coeff));
            st_nxt.valid = st_r.mid_valid;
            product = 65'(st_r.mid_value) * 65'(signed'({1'b0, gain_coeff}));
            st_nxt.value = gain_disable ? st_r.mid_value
                         : 40'(product >>> cal_path_pkg::GAIN_FRAC);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign out_valid = st_r.valid;
    assign out_value = st_r.value;
endmodule : cal_stage
`default_nettype wire

// *** logic/adc_result_calibration_path.sv ***
// result formatting, calibration coefficients and serial register port
// Notes on behaviour
// - result register 24-bit, read only; writes ignored
// - 18-bit result in bits 23:6, bits 5:0 read zero
// - result shifts out MSB first
// - unipolar range is always straight binary
// - bipolar: format bit 1 gives offset binary, 0 two's complement
// - two's complement: -full 0x20000, zero 0x00000, +full 0x1FFFF
// - out-of-range inputs saturate at format minimum or maximum
// - system offset: 24-bit two's complement, shifted MSB first
// - system coefficients kept until rewritten or system calibration
// - system offset subtracted while its disable bit is 0
// - system offset after self corrections, before system gain and range scaling
// - system gain applied while its disable bit is 0
// - system gain scales up to just under 4x, residual within 2 LSB
// - self coefficients kept until rewritten or self calibration
// - self offset subtracted first while its disable bit is 0
// - self gain applied after self offset, before system corrections
// - writes to self gain coefficient ignored while calibration is active
// - self gain scales up to just under 4x, residual within 2 LSB
// - 60 Hz: codes decode to single and continuous rates
// - 50 Hz: codes decode to single and continuous rates
// - range select 1 gives unipolar, 0 gives bipolar
// - result read clears ready once another conversion starts
`timescale 1ns/1ps
`default_nettype none
module adc_result_calibration_path
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        raw_valid,
    input  wire logic [23:0] raw_sample,
    input  wire logic        unipolar_select,
    input  wire logic        format_select,
    input  wire logic        mains_freq_select,
    input  wire logic [2:0]  rate_code,
    input  wire logic        system_offset_disable,
    input  wire logic        system_gain_disable,
    input  wire logic        self_offset_disable,
    input  wire logic        self_gain_disable,
    input  wire logic        calibration_active,
    input  wire logic        conversion_start,
    input  wire logic        self_cal_done,
    input  wire logic [23:0] self_cal_offset,
    input  wire logic [23:0] self_cal_gain,
    input  wire logic        system_cal_done,
    input  wire logic [23:0] system_cal_offset,
    input  wire logic [23:0] system_cal_gain,
    input  wire logic        reg_start,
    input  wire logic        reg_write,
    input  wire logic [2:0]  reg_select,
    input  wire logic        reg_bit_strobe,
    input  wire logic        reg_bit_in,
    output logic             reg_bit_out,
    output logic             reg_done,
    output logic             ready,
    output logic             over_range,
    output logic             under_range,
    output logic [19:0]      single_rate_msps,
    output logic [19:0]      continuous_rate_msps
);
    typedef struct packed
    {
        logic [23:0]                 result;
        logic [23:0]                 sys_offset;
        logic [23:0]                 sys_gain;
        logic [23:0]                 self_offset;
        logic [23:0]                 self_gain;
        logic                        ready;
        logic                        read_pending;
        logic                        over;
        logic                        under;
        logic                        fmt_valid;
        logic [17:0]                 fmt_code;
        logic                        fmt_over;
        logic                        fmt_under;
        cal_path_pkg::shift_state_e  sh_state;
        logic [23:0]                 sh_reg;
        logic [4:0]                  sh_cnt;
        logic                        sh_write;
        logic [2:0]                  sh_sel;
        logic                        bit_out;
        logic                        done;
        logic [19:0]                 rate_single;
        logic [19:0]                 rate_cont;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic               self_valid;
    logic signed [39:0] self_value;
    logic               sys_valid;
    logic signed [39:0] sys_value;
    logic signed [39:0] scaled;
    logic signed [39:0] biased;
    logic [23:0]        wr_word;

    // self offset then self gain, then system offset then system gain
    cal_stage u_self_stage
    (
        .clk_sys        (clk_sys),
        .reset_n        (reset_n),
        .clk_en         (clk_en),
        .in_valid       (raw_valid),
        .in_value       (40'(signed'(raw_sample))),
        .offset_coeff   (st_r.self_offset),
        .gain_coeff     (st_r.self_gain),
        .offset_disable (self_offset_disable),
        .gain_disable   (self_gain_disable),
        .out_valid      (self_valid),
        .out_value      (self_value)
    );

    cal_stage u_sys_stage
    (
        .clk_sys        (clk_sys),
        .reset_n        (reset_n),
        .clk_en         (clk_en),
        .in_valid       (self_valid),
        .in_value       (self_value),
        .offset_coeff   (st_r.sys_offset),
        .gain_coeff     (st_r.sys_gain),
        .offset_disable (system_offset_disable),
        .gain_disable   (system_gain_disable),
        .out_valid      (sys_valid),
        .out_value      (sys_value)
    );

    always_comb
    begin
        st_nxt = st_r;
        scaled = 40'sd0;
        biased = 40'sd0;
        wr_word = {st_r.sh_reg[22:0], reg_bit_in};
        if (clk_en)
        begin
            // range scaling: unipolar 2x, bipolar 1x
            scaled = unipolar_select ? (sys_value <<< 1) : sys_value;
            // format and clamp after every enabled correction
            st_nxt.fmt_valid = sys_valid;
            st_nxt.fmt_over = 1'b0;
            st_nxt.fmt_under = 1'b0;
            if (unipolar_select)
            begin
                biased = scaled >>> 6;
                if (biased > 40'sd262143)
                begin
                    st_nxt.fmt_code = cal_path_pkg::UNI_MAX;
                    st_nxt.fmt_over = 1'b1;
                end
                else if (biased < 40'sd0)
                begin
                    st_nxt.fmt_code = cal_path_pkg::UNI_MIN;
                    st_nxt.fmt_under = 1'b1;
                end
                else
                    st_nxt.fmt_code = biased[17:0];
            end
            else
            begin
                biased = scaled >>> 6;
                if (biased > 40'sd131071)
                begin
                    st_nxt.fmt_code = cal_path_pkg::TWOS_MAX;
                    st_nxt.fmt_over = 1'b1;
                end
                else if (biased < -40'sd131072)
                begin
                    st_nxt.fmt_code = cal_path_pkg::TWOS_MIN;
                    st_nxt.fmt_under = 1'b1;
                end
                else
                    st_nxt.fmt_code = biased[17:0];
                if (format_select)
                    st_nxt.fmt_code = st_nxt.fmt_code ^ cal_path_pkg::OFFB_MID;
            end

            // store result, top aligned, low bits zero
            if (st_r.fmt_valid)
            begin
                st_nxt.result = {st_r.fmt_code, {cal_path_pkg::PAD_W{1'b0}}};
                st_nxt.over = st_r.fmt_over;
                st_nxt.under = st_r.fmt_under;
                st_nxt.ready = 1'b1;
                st_nxt.read_pending = 1'b0;
            end

            // ready clears after a read and a new conversion
            if (st_r.read_pending && conversion_start && !st_r.fmt_valid)
            begin
                st_nxt.ready = 1'b0;
                st_nxt.read_pending = 1'b0;
            end

            // rate decode
            if (mains_freq_select)
            begin
                st_nxt.rate_single = cal_path_pkg::RATE_50_SINGLE[rate_code];
                st_nxt.rate_cont = cal_path_pkg::RATE_50_CONT[rate_code];
            end
            else
            begin
                st_nxt.rate_single = cal_path_pkg::RATE_60_SINGLE[rate_code];
                st_nxt.rate_cont = cal_path_pkg::RATE_60_CONT[rate_code];
            end

            // calibration overwrites host values
            if (self_cal_done)
            begin
                st_nxt.self_offset = self_cal_offset;
                st_nxt.self_gain = self_cal_gain;
            end
            if (system_cal_done)
            begin
                st_nxt.sys_offset = system_cal_offset;
                st_nxt.sys_gain = system_cal_gain;
            end

            // serial register shifter, msb first
            st_nxt.done = 1'b0;
            case (st_r.sh_state)
                cal_path_pkg::SH_IDLE:
                begin
                    if (reg_start)
                    begin
                        st_nxt.sh_state = cal_path_pkg::SH_LOAD;
                        st_nxt.sh_write = reg_write;
                        st_nxt.sh_sel = reg_select;
                    end
                end
                cal_path_pkg::SH_LOAD:
                begin
                    case (st_r.sh_sel)
                        cal_path_pkg::SEL_RESULT:      st_nxt.sh_reg = st_r.result;
                        cal_path_pkg::SEL_SYS_OFFSET:  st_nxt.sh_reg = st_r.sys_offset;
                        cal_path_pkg::SEL_SYS_GAIN:    st_nxt.sh_reg = st_r.sys_gain;
                        cal_path_pkg::SEL_SELF_OFFSET: st_nxt.sh_reg = st_r.self_offset;
                        cal_path_pkg::SEL_SELF_GAIN:   st_nxt.sh_reg = st_r.self_gain;
                        default:                       st_nxt.sh_reg = 24'h000000;
                    endcase
                    st_nxt.bit_out = st_nxt.sh_reg[23];
                    st_nxt.sh_cnt = 5'h00;
                    st_nxt.sh_state = cal_path_pkg::SH_SHIFT;
                end
                cal_path_pkg::SH_SHIFT:
                begin
                    if (reg_bit_strobe)
                    begin
                        st_nxt.sh_reg = wr_word;
                        st_nxt.bit_out = st_r.sh_reg[22];
                        st_nxt.sh_cnt = st_r.sh_cnt + 5'h01;
                        if (st_r.sh_cnt == cal_path_pkg::LAST_BIT)
                        begin
                            st_nxt.sh_state = cal_path_pkg::SH_IDLE;
                            st_nxt.done = 1'b1;
                            st_nxt.bit_out = 1'b0;
                            if (st_r.sh_write)
                            begin
                                case (st_r.sh_sel)
                                    cal_path_pkg::SEL_SYS_OFFSET:
                                        st_nxt.sys_offset = wr_word;
                                    cal_path_pkg::SEL_SYS_GAIN:
                                        st_nxt.sys_gain = wr_word;
                                    cal_path_pkg::SEL_SELF_OFFSET:
                                        st_nxt.self_offset = wr_word;
                                    cal_path_pkg::SEL_SELF_GAIN:
                                        if (!calibration_active)
                                            st_nxt.self_gain = wr_word;
                                    default:
                                        st_nxt.sh_write = 1'b0;
                                endcase
                            end
                            else if (st_r.sh_sel == cal_path_pkg::SEL_RESULT)
                            begin
                                st_nxt.read_pending = 1'b1;
                                if (conversion_start)
                                begin
                                    st_nxt.ready = 1'b0;
                                    st_nxt.read_pending = 1'b0;
                                end
                            end
                        end
                    end
                end
                default:
                    st_nxt.sh_state = cal_path_pkg::SH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= '0;
            st_r.result <= cal_path_pkg::RESULT_RESET;
            st_r.sys_offset <= cal_path_pkg::COEFF_RESET;
            st_r.sys_gain <= cal_path_pkg::COEFF_RESET;
            st_r.self_offset <= cal_path_pkg::COEFF_RESET;
            st_r.self_gain <= cal_path_pkg::COEFF_RESET;
            st_r.sh_state <= cal_path_pkg::SH_IDLE;
        end
        else
            st_r <= st_nxt;
    end

    assign reg_bit_out = st_r.bit_out;
    assign reg_done = st_r.done;
    assign ready = st_r.ready;
    assign over_range = st_r.over;
    assign under_range = st_r.under;
    assign single_rate_msps = st_r.rate_single;
    assign continuous_rate_msps = st_r.rate_cont;
endmodule : adc_result_calibration_path
`default_nettype wire

// *** testbench/adc_result_calibration_path_properties.sv ***
// checker for the result and calibration path ports
`timescale 1ns/1ps
`default_nettype none
module adc_result_calibration_path_properties
(
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        raw_valid,
    input wire logic        mains_freq_select,
    input wire logic [2:0]  rate_code,
    input wire logic        conversion_start,
    input wire logic        reg_start,
    input wire logic        reg_write,
    input wire logic [2:0]  reg_select,
    input wire logic        reg_bit_strobe,
    input wire logic        reg_bit_out,
    input wire logic        reg_done,
    input wire logic        ready,
    input wire logic        over_range,
    input wire logic        under_range,
    input wire logic [19:0] single_rate_msps,
    input wire logic [19:0] continuous_rate_msps
);
    logic       live_r;
    logic       rd_res_r;
    logic [4:0] cnt_r;
    // strobes since access start
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            live_r   <= 1'b0;
            rd_res_r <= 1'b0;
            cnt_r    <= 5'h00;
        end
        else
        begin
            live_r <= 1'b1;
            if (reg_start)
            begin
                rd_res_r <= !reg_write && reg_select == cal_path_pkg::SEL_RESULT;
                cnt_r    <= 5'h00;
            end
            else if (reg_bit_strobe)
                cnt_r <= cnt_r + 5'h01;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_taken;
        raw_valid && clk_en ##1 clk_en [*5];
    endsequence
    sequence s_quiet;
        (!reg_bit_strobe && !reg_start) [*4];
    endsequence
    a_result_latency: assert property (s_taken |=> ready)
        else $error("result not stored on time");
    a_ready_hold: assert property (ready && !conversion_start |=> ready)
        else $error("ready dropped early");
    a_flags_exclusive: assert property (!(over_range && under_range))
        else $error("both range flags set");
    a_low_bits_zero: assert property (rd_res_r && reg_bit_strobe && cnt_r >= 5'h12 |-> !reg_bit_out)
        else $error("result pad bit read as one");
    a_bit_out_stable: assert property (s_quiet |=> $stable(reg_bit_out))
        else $error("read bit changed unstrobed");
    a_done_after_last: assert property (reg_done |-> cnt_r == 5'h18)
        else $error("done before 24th bit");
    a_rate_single: assert property (live_r && $past(clk_en) |-> single_rate_msps == ($past(
        mains_freq_select) ? cal_path_pkg::RATE_50_SINGLE[$past(rate_code)]
        : cal_path_pkg::RATE_60_SINGLE[$past(rate_code)]))
        else $error("single cycle rate decode wrong");
    a_rate_cont: assert property (live_r && $past(clk_en) |-> continuous_rate_msps == ($past(
        mains_freq_select) ? cal_path_pkg::RATE_50_CONT[$past(rate_code)]
        : cal_path_pkg::RATE_60_CONT[$past(rate_code)]))
        else $error("cont rate decode wrong");
endmodule : adc_result_calibration_path_properties
bind adc_result_calibration_path adc_result_calibration_path_properties chk
(
    .clk_sys, .reset_n, .clk_en, .raw_valid, .mains_freq_select, .rate_code,
    .conversion_start, .reg_start, .reg_write, .reg_select, .reg_bit_strobe,
    .reg_bit_out, .reg_done, .ready, .over_range, .under_range,
    .single_rate_msps, .continuous_rate_msps
);
`default_nettype wire

// *** testbench/reg_host_model.sv ***
// host side of the serial register port
`timescale 1ns/1ps
`default_nettype none
module reg_host_model
(
    input  wire logic  clk_sys,
    input  wire logic  reg_bit_out,
    input  wire logic  reg_done,
    output logic       reg_start = 1'b0,
    output logic       reg_write = 1'b0,
    output logic [2:0] reg_select = 3'h7,
    output logic       reg_bit_strobe = 1'b0,
    output logic       reg_bit_in = 1'b0
);
    task automatic access(input logic wr, input logic [2:0] sel, input logic [23:0] wd,
                          output logic [23:0] rdv, output logic dn);
        @(negedge clk_sys);
        reg_start  = 1'b1;
        reg_write  = wr;
        reg_select = sel;
        @(negedge clk_sys);
        reg_start = 1'b0;
        repeat (2) @(negedge clk_sys);
        for (int i = 0; i < 24; i++)
        begin
            rdv[23 - i]    = reg_bit_out;
            reg_bit_strobe = 1'b1;
            reg_bit_in     = wd[23 - i];
            @(negedge clk_sys);
            reg_bit_strobe = 1'b0;
            dn             = reg_done;
            reg_bit_in     = ~reg_bit_in;
            @(negedge clk_sys);
        end
        repeat (2) @(negedge clk_sys);
        reg_select = ~sel;
    endtask : access
endmodule : reg_host_model
`default_nettype wire

// *** testbench/adc_result_calibration_path_test.sv ***
// self-checking bench for the result and calibration path
`timescale 1ns/1ps
`default_nettype none
module adc_result_calibration_path_test;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        raw_valid = 1'b0;
    logic [23:0] raw_sample = 24'h000000;
    logic        unipolar_select = 1'b1;
    logic        format_select = 1'b0;
    logic        mains_freq_select = 1'b0;
    logic [2:0]  rate_code = 3'h0;
    logic [3:0]  dis = 4'hF;
    logic        calibration_active = 1'b0;
    logic        conversion_start = 1'b0;
    logic        cal_done = 1'b0;
    logic        reg_start, reg_write, reg_bit_strobe, reg_bit_in;
    logic [2:0]  reg_select;
    logic        reg_bit_out, reg_done, ready, over_range, under_range;
    logic [19:0] single_rate_msps, continuous_rate_msps;
    logic [23:0] rd_v;
    logic        dn_v;
    int          bad_count = 0;
    int          n_tests = 0;
    logic [19:0] rates [32] = '{20'h3E8, 20'h9C4, 20'h1388, 20'h2710, 20'h3A98, 20'h7530,
        20'hEA60, 20'h1D4C0, 20'h0, 20'h0, 20'h0, 20'h0, 20'hEA60, 20'h1D4C0, 20'h3A980,
        20'h75300, 20'h341, 20'h820, 20'h104A, 20'h208A, 20'h30D4, 20'h61A8, 20'hC350,
        20'h186A0, 20'h0, 20'h0, 20'h0, 20'h0, 20'hC350, 20'h186A0, 20'h30D40, 20'h61A80};
    always #5 clk_sys = ~clk_sys;
    adc_result_calibration_path dut
    (
        .clk_sys, .reset_n, .clk_en, .raw_valid, .raw_sample, .unipolar_select,
        .format_select, .mains_freq_select, .rate_code, .self_offset_disable(dis[3]),
        .self_gain_disable(dis[2]), .system_offset_disable(dis[1]),
        .system_gain_disable(dis[0]), .calibration_active, .conversion_start,
        .self_cal_done(cal_done), .self_cal_offset(24'h0A0B0C), .self_cal_gain(24'h3C0000),
        .system_cal_done(cal_done), .system_cal_offset(24'hF01020),
        .system_cal_gain(24'h450000), .reg_start, .reg_write, .reg_select, .reg_bit_strobe,
        .reg_bit_in, .reg_bit_out, .reg_done, .ready, .over_range, .under_range,
        .single_rate_msps, .continuous_rate_msps
    );
    reg_host_model host
    (
        .clk_sys, .reg_bit_out, .reg_done, .reg_start, .reg_write, .reg_select,
        .reg_bit_strobe, .reg_bit_in
    );
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [2:0] sel, input logic [23:0] d);
        host.access(1'b1, sel, d, rd_v, dn_v);
        check("write done", {23'h0, dn_v}, 24'h000001);
    endtask : wr
    task automatic rd(input logic [2:0] sel, input logic [23:0] exp);
        host.access(1'b0, sel, 24'h000000, rd_v, dn_v);
        check("register read", rd_v, exp);
    endtask : rd
    task automatic feed(input logic [23:0] raw);
        @(negedge clk_sys);
        raw_sample = raw;
        raw_valid  = 1'b1;
        @(negedge clk_sys);
        raw_valid  = 1'b0;
        raw_sample = ~raw;
        repeat (6) @(negedge clk_sys);
    endtask : feed
    task automatic conv(input logic u, input logic f, input logic [23:0] raw,
                        input logic [17:0] code, input logic [1:0] flags);
        unipolar_select = u;
        format_select   = f;
        feed(raw);
        check("range flags", {22'h0, over_range, under_range}, {22'h0, flags});
        rd(3'h0, {code, 6'h00});
    endtask : conv
    task automatic pulse_start();
        conversion_start = 1'b1;
        @(negedge clk_sys);
        conversion_start = 1'b0;
        @(negedge clk_sys);
    endtask : pulse_start
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1'b1;
        for (int s = 0; s < 6; s++)
            rd(s[2:0], 24'h000000);
        $display("reset values done");
        for (int s = 1; s < 5; s++)
            wr(s[2:0], 24'h5A0000 ^ s[23:0]);
        for (int s = 1; s < 5; s++)
            rd(s[2:0], 24'h5A0000 ^ s[23:0]);
        @(negedge clk_sys);
        cal_done = 1'b1;
        @(negedge clk_sys);
        cal_done = 1'b0;
        rd(3'h1, 24'hF01020);
        rd(3'h2, 24'h450000);
        rd(3'h3, 24'h0A0B0C);
        calibration_active = 1'b1;
        wr(3'h4, 24'hABCDEF);
        calibration_active = 1'b0;
        rd(3'h4, 24'h3C0000);
        $display("coefficient access done");
        conv(1'b1, 1'b0, 24'h000000, 18'h00000, 2'b00);
        conv(1'b1, 1'b0, 24'h400000, 18'h20000, 2'b00);
        conv(1'b1, 1'b1, 24'h7FFFFF, 18'h3FFFF, 2'b00);
        conv(1'b1, 1'b0, 24'hC00000, 18'h00000, 2'b01);
        conv(1'b0, 1'b0, 24'h800000, 18'h20000, 2'b00);
        conv(1'b0, 1'b0, 24'h000000, 18'h00000, 2'b00);
        conv(1'b0, 1'b0, 24'h7FFFFF, 18'h1FFFF, 2'b00);
        conv(1'b0, 1'b1, 24'h000000, 18'h20000, 2'b00);
        conv(1'b0, 1'b1, 24'h800000, 18'h00000, 2'b00);
        conv(1'b0, 1'b1, 24'h7FFFFF, 18'h3FFFF, 2'b00);
        $display("format tests done");
        wr(3'h1, 24'hFFF000);
        dis = 4'hD;
        conv(1'b0, 1'b0, 24'h7FFFFF, 18'h1FFFF, 2'b10);
        wr(3'h1, 24'h001000);
        conv(1'b0, 1'b0, 24'h800000, 18'h20000, 2'b01);
        wr(3'h1, 24'h080000);
        dis = 4'hF;
        conv(1'b1, 1'b0, 24'h400000, 18'h20000, 2'b00);
        dis = 4'hD;
        conv(1'b1, 1'b0, 24'h400000, 18'h1C000, 2'b00);
        wr(3'h3, 24'h200000);
        wr(3'h4, 24'h200000);
        wr(3'h2, 24'h600000);
        dis = 4'h3;
        conv(1'b0, 1'b0, 24'h400000, 18'h04000, 2'b00);
        dis = 4'h0;
        conv(1'b0, 1'b0, 24'h400000, 18'h03000, 2'b00);
        dis = 4'h1;
        conv(1'b0, 1'b0, 24'h400000, 18'h02000, 2'b00);
        $display("calibration order done");
        dis = 4'hF;
        feed(24'h400000);
        check("ready", {23'h0, ready}, 24'h000001);
        pulse_start();
        check("ready", {23'h0, ready}, 24'h000001);
        wr(3'h0, 24'hFFFFFF);
        rd(3'h0, 24'h400000);
        pulse_start();
        check("ready", {23'h0, ready}, 24'h000000);
        $display("ready tests done");
        for (int m = 0; m < 2; m++)
            for (int c = 0; c < 8; c++)
            begin
                mains_freq_select = m[0];
                rate_code         = c[2:0];
                repeat (2) @(negedge clk_sys);
                check("single rate", {4'h0, single_rate_msps}, {4'h0, rates[m * 16 + c]});
                check("cont rate", {4'h0, continuous_rate_msps}, {4'h0, rates[m * 16 + 8 + c]});
            end
        clk_en    = 1'b0;
        rate_code = 3'h0;
        repeat (2) @(negedge clk_sys);
        check("frozen rate", {4'h0, single_rate_msps}, {4'h0, rates[23]});
        clk_en    = 1'b1;
        $display("rate decode done");
        report_and_stop();
    end
endmodule : adc_result_calibration_path_test
`default_nettype wire
